// >>> hdl/clock_distribution_dividers.sv
// What this block does
// RULE_01: seven clock sources feed every clock tree
// RULE_02: master clock selects the fastest source; code uses whichever source master_sel picks
// RULE_03: sixteen-bit divider makes bus clock from master
// RULE_04: processor divider takes bus clock as source
// RULE_05: eight programmable digital dividers, any source
// RULE_06: four more dividers for analog parts
// RULE_07: analog dividers have programmable skew delay
// RULE_08: each divider has eight-way source mux; bus and cpu dividers tie theirs to input 0
// RULE_09: ratio two upward, about half duty
// RULE_10: outputs retimed to master clock, deglitched; code retimes them to clk_sys
// RULE_11: digital output chains back as source
// RULE_12: extra interconnect clock per digital divider
// RULE_13: pin and logic clocks enter as sources
// RULE_14: usb clock at forty-eight megahertz
// RULE_15: usb clock crosses through synchroniser
// RULE_16: usb clock from direct or doubled source
// RULE_17: watch crystal drives sleep tick, second pulse
// RULE_18: watch crystal has two power modes
// RULE_19: doubler turns twenty-four into forty-eight
// RULE_20: disabled low, changes at period boundary
// RULE_21: reset disables dividers, master on internal
module clock_distribution_dividers
#(
  parameter int RTC_DIV = clkdist_pkg::WATCH_EDGES_PER_SEC
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [clkdist_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [clkdist_pkg::NUM_SRC-1:0] clk_src_pins,
  input wire logic [clkdist_pkg::NUM_DIG-1:0] interconnect_clk,
  input wire logic usb_interconnect_48,
  output logic master_clk_out,
  output wire logic bus_clk_out,
  output wire logic cpu_clk_out,
  output wire logic [clkdist_pkg::NUM_DIG-1:0] dig_clk_out,
  output wire logic [clkdist_pkg::NUM_ANA-1:0] ana_clk_out,
  output logic usb_clk_out,
  output logic sleep_tick,
  output logic rtc_second,
  output logic watch_low_power
);

  localparam logic [clkdist_pkg::RTC_CNT_W-1:0] RTC_LAST =
    clkdist_pkg::RTC_CNT_W'(RTC_DIV - 1);

  typedef struct packed {
    logic [clkdist_pkg::PIN_W-1:0] sync1;
    logic [clkdist_pkg::PIN_W-1:0] sync2;
    logic [clkdist_pkg::PIN_W-1:0] sync3;
    logic [clkdist_pkg::PIN_W-1:0] filt;
    logic [clkdist_pkg::SEL_W-1:0] master_sel;
    logic usb_sel;
    logic [1:0] dbl_src;
    logic watch_lp;
    logic [clkdist_pkg::DIV_W-1:0] bus_ratio;
    logic bus_en;
    logic [clkdist_pkg::DIV_W-1:0] cpu_ratio;
    logic cpu_en;
    logic [clkdist_pkg::NUM_DIG-1:0][clkdist_pkg::DIV_W-1:0] dig_ratio;
    logic [clkdist_pkg::NUM_DIG-1:0][clkdist_pkg::SEL_W-1:0] dig_sel;
    logic [clkdist_pkg::NUM_DIG-1:0] dig_en;
    logic [clkdist_pkg::NUM_DIG-1:0] dig_chain;
    logic [clkdist_pkg::NUM_ANA-1:0][clkdist_pkg::DIV_W-1:0] ana_ratio;
    logic [clkdist_pkg::NUM_ANA-1:0][clkdist_pkg::SEL_W-1:0] ana_sel;
    logic [clkdist_pkg::NUM_ANA-1:0] ana_en;
    logic [clkdist_pkg::NUM_ANA-1:0][clkdist_pkg::SKEW_W-1:0] ana_skew;
    logic master_clk;
    logic usb_clk;
    logic dbl_prev;
    logic watch_prev;
    logic [clkdist_pkg::RTC_CNT_W-1:0] rtc_cnt;
    logic rtc_second;
    logic sleep_tick;
    logic [31:0] prdata;
    logic pslverr;
  } top_state_type;

  top_state_type st_reg;
  top_state_type st_next;

  logic [clkdist_pkg::NUM_SRC-1:0] srcs;
  logic [7:0] srcs8;
  logic [clkdist_pkg::NUM_DIG-1:0] ic_clk;
  logic usb48;
  logic dbl_in;
  logic watch_rise;
  logic setup_ph;
  logic access_ph;
  logic hit;
  logic [31:0] rd_word;
  logic [2:0] dig_idx;
  logic [1:0] ana_idx;
  logic dig_page;
  logic ana_page;
  logic [clkdist_pkg::SKEW_W-1:0] unused_skew;

  // filtered pin view: seven sources, eight extra clocks, usb 48 [RULE_01] [RULE_13]
  assign srcs = st_reg.filt[clkdist_pkg::NUM_SRC-1:0];
  assign srcs8 = {1'b0, srcs}; // unused eighth master choice reads low
  assign ic_clk = st_reg.filt[14:7]; // [RULE_12]
  assign usb48 = st_reg.filt[15];
  assign unused_skew = '0;

  // apb decode; registers are one aligned word each
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign dig_idx = paddr[4:2];
  assign ana_idx = paddr[3:2];
  assign dig_page = (paddr[7:5] == clkdist_pkg::OFF_DIG_PAGE) && (paddr[1:0] == 2'h0);
  assign ana_page = (paddr[7:4] == clkdist_pkg::OFF_ANA_PAGE) && (paddr[1:0] == 2'h0);

  // read mux; unmapped addresses read zero and flag an error
  always_comb
  begin
    rd_word = '0;
    hit = 1'b1;
    if (paddr == clkdist_pkg::OFF_CTRL)
    begin
      rd_word[clkdist_pkg::CTRL_MASTER_LSB +: 3] = st_reg.master_sel;
      rd_word[clkdist_pkg::CTRL_USB_SEL_BIT] = st_reg.usb_sel;
      rd_word[clkdist_pkg::CTRL_DBL_LSB +: 2] = st_reg.dbl_src;
      rd_word[clkdist_pkg::CTRL_WATCH_LP_BIT] = st_reg.watch_lp;
    end
    else if (paddr == clkdist_pkg::OFF_BUS_DIV)
    begin
      rd_word[clkdist_pkg::DIV_RATIO_LSB +: 16] = st_reg.bus_ratio;
      rd_word[clkdist_pkg::DIV_EN_BIT] = st_reg.bus_en;
    end
    else if (paddr == clkdist_pkg::OFF_CPU_DIV)
    begin
      rd_word[clkdist_pkg::DIV_RATIO_LSB +: 16] = st_reg.cpu_ratio;
      rd_word[clkdist_pkg::DIV_EN_BIT] = st_reg.cpu_en;
    end
    else if (paddr == clkdist_pkg::OFF_STATUS)
      rd_word[15:0] = {usb_clk_out, st_reg.master_clk, cpu_clk_out, bus_clk_out,
        ana_clk_out, dig_clk_out};
    else if (dig_page)
    begin
      rd_word[clkdist_pkg::DIV_RATIO_LSB +: 16] = st_reg.dig_ratio[dig_idx];
      rd_word[clkdist_pkg::DIV_SEL_LSB +: 3] = st_reg.dig_sel[dig_idx];
      rd_word[clkdist_pkg::DIV_EN_BIT] = st_reg.dig_en[dig_idx];
      rd_word[clkdist_pkg::DIV_CHAIN_BIT] = st_reg.dig_chain[dig_idx];
    end
    else if (ana_page)
    begin
      rd_word[clkdist_pkg::DIV_RATIO_LSB +: 16] = st_reg.ana_ratio[ana_idx];
      rd_word[clkdist_pkg::DIV_SEL_LSB +: 3] = st_reg.ana_sel[ana_idx];
      rd_word[clkdist_pkg::DIV_EN_BIT] = st_reg.ana_en[ana_idx];
      rd_word[clkdist_pkg::DIV_SKEW_LSB +: 4] = st_reg.ana_skew[ana_idx];
    end
    else
      hit = 1'b0;
  end

  // next state: synchronisers, master mux, usb, watch, register writes
  always_comb
  begin
    st_next = st_reg;
    // three flops, a change counts once the second and third agree [RULE_13] [RULE_15]
    st_next.sync1 = {usb_interconnect_48, interconnect_clk, clk_src_pins};
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    st_next.filt = (~(st_reg.sync2 ^ st_reg.sync3) & st_reg.sync2) |
      ((st_reg.sync2 ^ st_reg.sync3) & st_reg.filt);
    // master clock reference pick [RULE_02]
    st_next.master_clk = srcs8[st_reg.master_sel];
    // doubler: one pulse per edge of the 24 MHz source [RULE_19]
    case (st_reg.dbl_src)
      clkdist_pkg::DBL_FROM_INTERNAL: dbl_in = srcs[clkdist_pkg::SRC_FAST_INTERNAL];
      clkdist_pkg::DBL_FROM_INTERCONNECT: dbl_in = srcs[clkdist_pkg::SRC_INTERCONNECT];
      default: dbl_in = srcs[clkdist_pkg::SRC_FAST_CRYSTAL];
    endcase
    st_next.dbl_prev = dbl_in;
    // usb domain clock, direct 48 or doubled 24 [RULE_14] [RULE_16]
    st_next.usb_clk = st_reg.usb_sel ? (dbl_in ^ st_reg.dbl_prev) : usb48;
    // watch crystal: sleep tick on each rising edge, second pulse after a full count [RULE_17]
    watch_rise = srcs[clkdist_pkg::SRC_WATCH_CRYSTAL] & ~st_reg.watch_prev;
    st_next.watch_prev = srcs[clkdist_pkg::SRC_WATCH_CRYSTAL];
    st_next.sleep_tick = watch_rise;
    st_next.rtc_second = 1'b0;
    if (watch_rise)
    begin
      if (st_reg.rtc_cnt == RTC_LAST)
      begin
        st_next.rtc_cnt = '0;
        st_next.rtc_second = 1'b1;
      end
      else
        st_next.rtc_cnt = st_reg.rtc_cnt + 16'h0001;
    end
    // read data and error are caught in the setup cycle, so both come from flops
    if (setup_ph)
    begin
      st_next.prdata = rd_word;
      st_next.pslverr = ~hit;
    end
    // writes take effect at the access edge; status is read only
    if (access_ph && pwrite)
    begin
      if (paddr == clkdist_pkg::OFF_CTRL)
      begin
        st_next.master_sel = pwdata[clkdist_pkg::CTRL_MASTER_LSB +: 3];
        st_next.usb_sel = pwdata[clkdist_pkg::CTRL_USB_SEL_BIT];
        st_next.dbl_src = pwdata[clkdist_pkg::CTRL_DBL_LSB +: 2];
        st_next.watch_lp = pwdata[clkdist_pkg::CTRL_WATCH_LP_BIT]; // [RULE_18]
      end
      else if (paddr == clkdist_pkg::OFF_BUS_DIV)
      begin
        st_next.bus_ratio = pwdata[clkdist_pkg::DIV_RATIO_LSB +: 16];
        st_next.bus_en = pwdata[clkdist_pkg::DIV_EN_BIT];
      end
      else if (paddr == clkdist_pkg::OFF_CPU_DIV)
      begin
        st_next.cpu_ratio = pwdata[clkdist_pkg::DIV_RATIO_LSB +: 16];
        st_next.cpu_en = pwdata[clkdist_pkg::DIV_EN_BIT];
      end
      else if (dig_page)
      begin
        st_next.dig_ratio[dig_idx] = pwdata[clkdist_pkg::DIV_RATIO_LSB +: 16];
        st_next.dig_sel[dig_idx] = pwdata[clkdist_pkg::DIV_SEL_LSB +: 3];
        st_next.dig_en[dig_idx] = pwdata[clkdist_pkg::DIV_EN_BIT];
        st_next.dig_chain[dig_idx] = pwdata[clkdist_pkg::DIV_CHAIN_BIT];
      end
      else if (ana_page)
      begin
        st_next.ana_ratio[ana_idx] = pwdata[clkdist_pkg::DIV_RATIO_LSB +: 16];
        st_next.ana_sel[ana_idx] = pwdata[clkdist_pkg::DIV_SEL_LSB +: 3];
        st_next.ana_en[ana_idx] = pwdata[clkdist_pkg::DIV_EN_BIT];
        st_next.ana_skew[ana_idx] = pwdata[clkdist_pkg::DIV_SKEW_LSB +: 4];
      end
    end
  end

  // all zero: dividers off, master on fast internal osc (index 0) [RULE_21]
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // bus divider runs off the master clock only [RULE_03]
  div_cfg_if bus_if();
  assign bus_if.en = st_reg.bus_en;
  assign bus_if.ratio = st_reg.bus_ratio;
  assign bus_if.sel = 3'h0;
  assign bus_if.skew = unused_skew;
  assign bus_if.src = {srcs, st_reg.master_clk};
  assign bus_clk_out = bus_if.out;
  clk_divider #(.HAS_SKEW(1'b0)) u_bus_div (.clk_sys(clk_sys), .rst_b(rst_b), .cfg(bus_if));

  // processor divider hangs off the bus clock, not the master [RULE_04]
  div_cfg_if cpu_if();
  assign cpu_if.en = st_reg.cpu_en;
  assign cpu_if.ratio = st_reg.cpu_ratio;
  assign cpu_if.sel = 3'h0;
  assign cpu_if.skew = unused_skew;
  assign cpu_if.src = {srcs, bus_clk_out};
  assign cpu_clk_out = cpu_if.out;
  clk_divider #(.HAS_SKEW(1'b0)) u_cpu_div (.clk_sys(clk_sys), .rst_b(rst_b), .cfg(cpu_if));

  // digital dividers; eighth input is own interconnect clock or chained neighbour
  for (genvar g = 0; g < clkdist_pkg::NUM_DIG; g++)
  begin : gen_dig
    div_cfg_if dig_if();
    assign dig_if.en = st_reg.dig_en[g]; // [RULE_05]
    assign dig_if.ratio = st_reg.dig_ratio[g];
    assign dig_if.sel = st_reg.dig_sel[g];
    assign dig_if.skew = unused_skew;
    assign dig_if.src = {st_reg.dig_chain[g] ? dig_clk_out[(g + 7) % 8] : ic_clk[g],
      srcs}; // [RULE_11] [RULE_12]
    assign dig_clk_out[g] = dig_if.out;
    clk_divider #(.HAS_SKEW(1'b0)) u_dig_div (.clk_sys(clk_sys), .rst_b(rst_b),
      .cfg(dig_if));
  end

  // analog dividers with skew; eighth input is the master clock
  for (genvar a = 0; a < clkdist_pkg::NUM_ANA; a++)
  begin : gen_ana
    div_cfg_if ana_if();
    assign ana_if.en = st_reg.ana_en[a]; // [RULE_06]
    assign ana_if.ratio = st_reg.ana_ratio[a];
    assign ana_if.sel = st_reg.ana_sel[a];
    assign ana_if.skew = st_reg.ana_skew[a]; // [RULE_07]
    assign ana_if.src = {st_reg.master_clk, srcs};
    assign ana_clk_out[a] = ana_if.out;
    clk_divider #(.HAS_SKEW(1'b1)) u_ana_div (.clk_sys(clk_sys), .rst_b(rst_b),
      .cfg(ana_if));
  end

  // outputs; apb never waits
  assign pready = 1'b1;
  assign prdata = st_reg.prdata;
  assign pslverr = st_reg.pslverr;
  assign master_clk_out = st_reg.master_clk;
  assign usb_clk_out = st_reg.usb_clk;
  assign sleep_tick = st_reg.sleep_tick;
  assign rtc_second = st_reg.rtc_second;
  assign watch_low_power = st_reg.watch_lp;

  reset_state_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_21]
    $rose(rst_b) |-> (st_reg.master_sel == 3'h0) && (st_reg.dig_en == '0) &&
    (st_reg.ana_en == '0) && !st_reg.bus_en && !st_reg.cpu_en)
    else $error("reset settings wrong");

  unmapped_err_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (setup_ph && !hit) ##1 access_ph |-> pslverr && (prdata == 32'h0000_0000))
    else $error("unmapped access not flagged");

  bus_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_03]
    (access_ph && pwrite && (paddr == 8'h04)) |=> st_reg.bus_ratio == $past(pwdata[15:0]))
    else $error("bus divider write lost");

  rtc_second_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_17]
    rtc_second |-> (st_reg.rtc_cnt == '0) && ($past(st_reg.rtc_cnt) == RTC_LAST) ##1
    !rtc_second)
    else $error("second pulse wrong");

  usb_double_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_19]
    $past(st_reg.usb_sel) |-> usb_clk_out == (st_reg.dbl_prev ^ $past(st_reg.dbl_prev)))
    else $error("doubled usb clock wrong");

  usb_direct_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_14]
    !$past(st_reg.usb_sel) |-> usb_clk_out == $past(usb48))
    else $error("direct usb clock wrong");

  pin_filter_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_13]
    ((st_reg.filt ^ $past(st_reg.filt)) & ($past(st_reg.sync2) ^ $past(st_reg.sync3))) == '0)
    else $error("pin filter passed an unsettled change");

  sleep_tick_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_17]
    sleep_tick == ($past(srcs[clkdist_pkg::SRC_WATCH_CRYSTAL]) && !$past(st_reg.watch_prev)))
    else $error("sleep tick wrong");

endmodule

// >>> include/clkdist_pkg.sv
package clkdist_pkg;

  // structure of the clock trees
  localparam int NUM_SRC = 7;
  localparam int NUM_DIG = 8;
  localparam int NUM_ANA = 4;
  localparam int DIV_W = 16;
  localparam int SEL_W = 3;
  localparam int SKEW_W = 4;
  localparam int PIN_W = 16;
  localparam int RTC_CNT_W = 16;
  localparam int APB_ADDR_W = 8;

  // system clock rate, MHz
  localparam int SYS_CLK_MHZ = 100;

  // source indices on the seven-way source bus
  localparam logic [SEL_W-1:0] SRC_FAST_INTERNAL = 3'h0;
  localparam logic [SEL_W-1:0] SRC_FAST_CRYSTAL = 3'h1;
  localparam logic [SEL_W-1:0] SRC_WATCH_CRYSTAL = 3'h2;
  localparam logic [SEL_W-1:0] SRC_SLOW_INTERNAL = 3'h3;
  localparam logic [SEL_W-1:0] SRC_PLL = 3'h4;
  localparam logic [SEL_W-1:0] SRC_INTERCONNECT = 3'h5;
  localparam logic [SEL_W-1:0] SRC_SLOW_FAST_TAP = 3'h6;
  localparam logic [SEL_W-1:0] SRC_LOCAL = 3'h7;

  // doubler input choices
  localparam logic [1:0] DBL_FROM_INTERNAL = 2'h0;
  localparam logic [1:0] DBL_FROM_INTERCONNECT = 2'h1;
  localparam logic [1:0] DBL_FROM_CRYSTAL = 2'h2;

  // register byte offsets
  localparam logic [APB_ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [APB_ADDR_W-1:0] OFF_BUS_DIV = 8'h04;
  localparam logic [APB_ADDR_W-1:0] OFF_CPU_DIV = 8'h08;
  localparam logic [APB_ADDR_W-1:0] OFF_STATUS = 8'h0c;
  localparam logic [2:0] OFF_DIG_PAGE = 3'h1;
  localparam logic [3:0] OFF_ANA_PAGE = 4'h4;

  // control word fields
  localparam int CTRL_MASTER_LSB = 0;
  localparam int CTRL_USB_SEL_BIT = 4;
  localparam int CTRL_DBL_LSB = 5;
  localparam int CTRL_WATCH_LP_BIT = 8;

  // divider word fields
  localparam int DIV_RATIO_LSB = 0;
  localparam int DIV_SEL_LSB = 16;
  localparam int DIV_EN_BIT = 20;
  localparam int DIV_CHAIN_BIT = 21;
  localparam int DIV_SKEW_LSB = 24;

  // smallest division ratio and watch crystal rate
  localparam logic [DIV_W-1:0] DIV_RATIO_MIN = 16'h0002;
  localparam int WATCH_EDGES_PER_SEC = 32768;

endpackage

// >>> include/div_cfg_if.sv
interface div_cfg_if;
  logic en;
  logic [clkdist_pkg::DIV_W-1:0] ratio;
  logic [clkdist_pkg::SEL_W-1:0] sel;
  logic [clkdist_pkg::SKEW_W-1:0] skew;
  logic [7:0] src;
  logic out;

  modport ctrl
  (
    output en,
    output ratio,
    output sel,
    output skew,
    output src,
    input out
  );

  modport div
  (
    input en,
    input ratio,
    input sel,
    input skew,
    input src,
    output out
  );
endinterface

// >>> hdl/clk_divider.sv
module clk_divider
#(
  parameter bit HAS_SKEW = 1'b0
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  div_cfg_if.div cfg
);

  typedef struct packed {
    logic en;
    logic [clkdist_pkg::DIV_W-1:0] ratio;
    logic [clkdist_pkg::SEL_W-1:0] sel;
    logic [clkdist_pkg::SKEW_W-1:0] skew;
    logic prev;
    logic [clkdist_pkg::DIV_W-1:0] cnt;
    logic out;
    logic [15:0] hist;
    logic tap;
  } div_state_type;

  div_state_type st_reg;
  div_state_type st_next;
  logic [clkdist_pkg::DIV_W-1:0] ratio_req;
  logic [clkdist_pkg::DIV_W-1:0] cnt_inc;
  logic rise;
  logic wrap;

  // divider core; settings only move at a period boundary so no runt pulse
  always_comb
  begin
    st_next = st_reg;
    ratio_req = (cfg.ratio < clkdist_pkg::DIV_RATIO_MIN) ? clkdist_pkg::DIV_RATIO_MIN
      : cfg.ratio; // [RULE_09]
    rise = cfg.src[st_reg.sel] & ~st_reg.prev; // [RULE_08]
    cnt_inc = st_reg.cnt + 16'h0001;
    wrap = rise && (cnt_inc == st_reg.ratio);
    st_next.prev = cfg.src[st_reg.sel];
    if (!st_reg.en || wrap)
    begin
      // boundary: take new setting, disabled divider sits low [RULE_20]
      st_next.en = cfg.en;
      st_next.ratio = ratio_req;
      st_next.sel = cfg.sel;
      st_next.skew = HAS_SKEW ? cfg.skew : 4'h0;
      st_next.cnt = '0;
      st_next.out = cfg.en;
      st_next.prev = cfg.src[cfg.sel]; // new source must not fake an edge
    end
    else if (rise)
    begin
      st_next.cnt = cnt_inc;
      st_next.out = (cnt_inc < (st_reg.ratio >> 1)); // high half, low half [RULE_09]
    end
    // skew tap delays the edge by whole system clock cycles [RULE_07]
    st_next.hist = {st_reg.hist[14:0], st_reg.out};
    st_next.tap = (st_reg.skew == 4'h0) ? st_reg.out
      : st_reg.hist[st_reg.skew - 4'h1]; // [RULE_10]
  end

  // all state on the system clock clk_sys
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0; // [RULE_21]
    else
      st_reg <= st_next;
  end

  assign cfg.out = st_reg.tap; // retimed to clk_sys, never straight from the mux [RULE_10]

  dis_low_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_20]
    !st_reg.en |-> ##1 !st_reg.tap ##[0:16] !st_reg.tap)
    else $error("disabled divider output not low");

  duty_half_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_09]
    st_reg.en |-> (st_reg.out == (st_reg.cnt < (st_reg.ratio >> 1))) &&
    (st_reg.ratio >= 16'h0002))
    else $error("divider duty or ratio wrong");

  cnt_range_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_09]
    st_reg.en |-> st_reg.cnt < st_reg.ratio)
    else $error("divider count out of range");

  boundary_load_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_20]
    ($past(st_reg.en) && ($changed(st_reg.ratio) || $changed(st_reg.sel))) |->
    st_reg.cnt == '0)
    else $error("setting changed mid period");

  skew_delay_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE_07]
    (st_reg.skew == 4'h3) && $stable(st_reg.skew) && ($past(st_reg.skew, 4) == 4'h3) |->
    st_reg.tap == $past(st_reg.out, 4))
    else $error("skew delay wrong");

endmodule

// >>> sim/clk_src_model.sv
module clk_src_model
(
  output logic [6:0] clk_src_pins,
  output logic [7:0] interconnect_clk,
  output logic usb_interconnect_48
);
  timeunit 1ns;
  timeprecision 100ps;

  // free-running oscillators, offset so no edge lands on a clk_sys edge
  initial
  begin
    clk_src_pins = 7'h00;
    interconnect_clk = 8'h00;
    usb_interconnect_48 = 1'b0;
  end

  // source g runs at 160*(g+1) ns so every tree can be told apart
  for (genvar g = 0; g < 7; g++)
  begin : g_src
    initial
    begin
      #3;
      forever #(80 * (g + 1)) clk_src_pins[g] = ~clk_src_pins[g];
    end
  end

  // per-divider routed clocks at 240 ns, direct usb clock at 200 ns
  initial
  begin
    #7;
    forever #120 interconnect_clk = ~interconnect_clk;
  end
  initial
  begin
    #4;
    forever #100 usb_interconnect_48 = ~usb_interconnect_48;
  end
endmodule

// >>> sim/tb_top.sv
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("MISMATCH at %0t got %h expected %h", $time, (got), (exp)); \
    end \
  end

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, interconnect_clk, dig_clk_out;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] clk_src_pins;
  logic [3:0] ana_clk_out;
  logic usb_interconnect_48, master_clk_out, bus_clk_out, cpu_clk_out, usb_clk_out;
  logic sleep_tick, rtc_second, watch_low_power;
  logic [15:0] mon;
  int bad_count, total_checks, per, hi, k;

  // same bit order as the status word
  assign mon = {usb_clk_out, master_clk_out, cpu_clk_out, bus_clk_out, ana_clk_out, dig_clk_out};

  clk_src_model src_u (.clk_src_pins(clk_src_pins), .interconnect_clk(interconnect_clk),
    .usb_interconnect_48(usb_interconnect_48));

  // short second count keeps the run brief
  clock_distribution_dividers #(.RTC_DIV(4)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .clk_src_pins(clk_src_pins),
    .interconnect_clk(interconnect_clk), .usb_interconnect_48(usb_interconnect_48),
    .master_clk_out(master_clk_out), .bus_clk_out(bus_clk_out), .cpu_clk_out(cpu_clk_out),
    .dig_clk_out(dig_clk_out), .ana_clk_out(ana_clk_out), .usb_clk_out(usb_clk_out),
    .sleep_tick(sleep_tick), .rtc_second(rtc_second), .watch_low_power(watch_low_power));

  // 100 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one apb transfer; the answer is taken only at the edge where pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 100)
    begin
      n++;
      @(posedge clk_sys);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 100)
      bad_count++;
    if (n >= 100)
      end_sim();
  endtask

  // outputs are sampled on the falling edge, well clear of their updates
  task automatic wait_lvl(input int idx, input logic v);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (mon[idx] !== v && n < 2000)
    begin
      n++;
      @(negedge clk_sys);
    end
    if (n >= 2000)
      bad_count++;
    if (n >= 2000)
      end_sim();
  endtask

  // skips two periods so deferred settings land, then rounds to the 40 ns grid
  task automatic measure(input int idx, output int p, output int h);
    time t0, t1;
    for (int r = 0; r < 2; r++)
    begin
      wait_lvl(idx, 1'b0);
      wait_lvl(idx, 1'b1);
    end
    t0 = $time;
    wait_lvl(idx, 1'b0);
    h = int'((($time - t0) + 20) / 40 * 40);
    wait_lvl(idx, 1'b1);
    t1 = $time;
    p = int'(((t1 - t0) + 20) / 40 * 40);
  endtask

  function automatic logic [31:0] dw(logic [15:0] r, logic [2:0] s, logic ch, logic [3:0] sk);
    return {4'h0, sk, 2'h0, ch, 1'b1, 1'b0, s, r};
  endfunction

  task automatic t_regs();
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h0000_0000)
    `CHK(dig_clk_out, 8'h00)
    apb(1'b0, 8'hfc, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    apb(1'b1, 8'h0c, 32'hffff_ffff);
    `CHK(err, 1'b0)
    apb(1'b1, 8'h24, 32'h0007_1234);
    apb(1'b0, 8'h24, 32'h0);
    `CHK(rd, 32'h0007_1234)
  endtask

  // every digital divider with a different ratio; odd ratios check the duty split
  task automatic t_dig();
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, 8'h20 + 8'(4 * i), dw(16'(2 + i), 3'h0, 1'b0, 4'h0));
      measure(i, per, hi);
      `CHK(per, 160 * (2 + i))
      `CHK(hi, 160 * ((2 + i) / 2))
      apb(1'b1, 8'h20 + 8'(4 * i), 32'h0);
    end
  endtask

  // each source choice, the routed clock, chaining and the disable path
  task automatic t_src();
    for (int s = 0; s < 7; s++)
    begin
      apb(1'b1, 8'h24, dw(16'h0002, 3'(s), 1'b0, 4'h0));
      measure(1, per, hi);
      `CHK(per, 320 * (s + 1))
    end
    apb(1'b1, 8'h24, dw(16'h0001, 3'h7, 1'b0, 4'h0));
    measure(1, per, hi);
    `CHK(per, 480)
    apb(1'b1, 8'h20, dw(16'h0002, 3'h0, 1'b0, 4'h0));
    apb(1'b1, 8'h24, dw(16'h0002, 3'h7, 1'b1, 4'h0));
    measure(1, per, hi);
    `CHK(per, 640)
    apb(1'b1, 8'h24, 32'h0);
    repeat (200) @(negedge clk_sys);
    k = 0;
    repeat (300)
    begin
      @(negedge clk_sys);
      if (dig_clk_out[1] !== 1'b0)
        k++;
    end
    `CHK(k, 0)
  endtask

  task automatic t_trees();
    apb(1'b1, 8'h00, 32'h0000_0001);
    measure(14, per, hi);
    `CHK(per, 320)
    apb(1'b1, 8'h04, 32'h0010_0002);
    measure(12, per, hi);
    `CHK(per, 640)
    apb(1'b1, 8'h08, 32'h0010_0002);
    measure(13, per, hi);
    `CHK(per, 1280)
    apb(1'b1, 8'h40, dw(16'h0003, 3'h0, 1'b0, 4'h3));
    measure(8, per, hi);
    `CHK(per, 480)
    measure(15, per, hi);
    `CHK(per, 200)
  endtask

  // usb pulses counted over a window, clear of the source switch-over
  task automatic usb_pulses(input logic [31:0] ctrl, input int cyc, output int c);
    apb(1'b1, 8'h00, ctrl);
    repeat (20) @(negedge clk_sys);
    c = 0;
    repeat (cyc)
    begin
      @(negedge clk_sys);
      if (usb_clk_out === 1'b1)
        c++;
    end
  endtask

  // one pulse per source edge: internal 160 ns, crystal 320 ns, routed 960 ns
  task automatic t_usb_rtc();
    int n;
    apb(1'b1, 8'h00, 32'h0000_0110);
    @(negedge clk_sys);
    `CHK(watch_low_power, 1'b1)
    usb_pulses(32'h0000_0110, 160, k);
    `CHK(k >= 19 && k <= 21, 1'b1)
    usb_pulses(32'h0000_0150, 160, k);
    `CHK(k >= 9 && k <= 11, 1'b1)
    usb_pulses(32'h0000_0130, 480, k);
    `CHK(k >= 9 && k <= 11, 1'b1)
    n = 0;
    while (rtc_second !== 1'b1 && n < 2000)
    begin
      n++;
      @(negedge clk_sys);
    end
    k = 0;
    @(negedge clk_sys);
    while (rtc_second !== 1'b1 && n < 4000)
    begin
      if (sleep_tick === 1'b1)
        k++;
      n++;
      @(negedge clk_sys);
    end
    if (sleep_tick === 1'b1)
      k++;
    `CHK(k, 4)
    `CHK(n < 4000, 1'b1)
  endtask

  // mid-run reset puts every setting and divider output back to its start value
  task automatic t_reset();
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    `CHK({watch_low_power, rd}, 33'h0_0000_0000)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK(rd[13:0], 14'h0000)
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    bad_count = 0;
    total_checks = 0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_regs();
    t_dig();
    t_src();
    t_trees();
    t_usb_rtc();
    t_reset();
    end_sim();
  end
endmodule
